// ===== logic/cell_ins_pkg.sv
package cell_ins_pkg;
   // register indices (printed low offsets); byte address is four times the index
   localparam logic [7:0] IDX_CONTROL = 8'h13;
   localparam logic [7:0] IDX_BITS_31_24 = 8'h14;
   localparam logic [7:0] IDX_BITS_23_16 = 8'h15;
   localparam logic [7:0] IDX_BITS_15_8 = 8'h16;
   localparam logic [7:0] IDX_BITS_7_0 = 8'h17;
   localparam logic [7:0] IDX_STATUS = 8'h18;
   localparam int ADDR_W = 10;
   // control field positions
   localparam int CTL_SOC = 0;
   localparam int CTL_ROOM = 1;
   localparam int CTL_INS_RST_N = 2;
   localparam int CTL_EXT_READY = 3;
   localparam int CTL_EXT_RST_N = 4;
   localparam logic [7:0] CTL_RESET = 8'h14;
   localparam logic [7:0] CTL_RW_MASK = 8'h1D;
   localparam int WORDS_PER_CELL = 14;
   localparam int CELL_DEPTH = 4;

   typedef struct packed {
      logic soc;
      logic [31:0] data;
   } ins_word_s;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADDR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_s;
endpackage

// ===== logic/cell_ins_mem.sv
`timescale 1ns/10ps
`default_nettype none
module cell_ins_mem #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 56,
   parameter int AW = 6
) (
   input wire logic clk_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   initial begin
      if ((1 << AW) < DEPTH) $error("cell_ins_mem: AW too small for DEPTH");
   end

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule
`default_nettype wire

// ===== logic/rx_cell_insertion_write_port.sv
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] software loads each word as four byte writes, soc set for first word
// [R2] byte register 0x14 lands on word bits 31:24
// [R3] byte register 0x15 lands on word bits 23:16
// [R4] byte register 0x16 lands on word bits 15:8
// [R5] byte register 0x17 lands on word bits 7:0
// [R6] soc cleared after first word; later words continue the cell
// [R7] soc one tags the next committed word as first word of a cell
// [R8] room flag reads one while buffer can take another full cell
// [R9] rest of cell is thirteen more four-byte words
// [R10] data register reads return extraction data, never insertion data
// [R11] word commits on the bits 7:0 write, soc sampled at that moment
module rx_cell_insertion_write_port
   import cell_ins_pkg::*;
#(
   parameter int CELLS = CELL_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // extraction side supplies read data and cell-ready
   input wire logic [31:0] ext_word_i,
   input wire logic extract_cell_ready_i,
   // drain side toward the receive data path
   input wire logic word_ready_i,
   output logic word_valid_o,
   output logic [31:0] word_data_o,
   output logic word_soc_o,
   output logic ext_reset_o
);
   localparam int DEPTH = CELLS * WORDS_PER_CELL;
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   initial begin
      if (CELLS < 1) $error("CELLS must be at least 1");
   end

   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdat;
      logic [7:0] ctl;
      logic [23:0] hold;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [CW-1:0] count;
      logic mem_pending;
      logic out_valid;
      logic [31:0] out_data;
      logic out_soc;
      logic ovf;
   } state_s;

   state_s st;
   state_s next_st;
   ins_word_s wr_word;
   ins_word_s rd_word;
   logic wr_en;
   logic rd_en;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1)) begin
         return '0;
      end
      return p + AW'(1);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   cell_ins_mem #(
      .WIDTH(33),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .clk_i(clk_i),
      .wr_en_i(wr_en),
      .wr_addr_i(st.wptr),
      .wr_data_i(wr_word),
      .rd_addr_i(st.rptr),
      .rd_data_o(rd_word)
   );

   //////////////////////////////////////////////////////////////////////////
   logic req;
   logic wr_req;
   logic [7:0] idx;
   logic mapped;
   logic have_room;
   logic mem_full;
   logic out_take;

   always_comb begin
      next_st = st;
      req = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
      wr_req = req && wb_we_i && wb_sel_i[0];
      idx = 8'(wb_adr_i[ADDR_W-1:2]);
      mapped = (idx >= IDX_CONTROL) && (idx <= IDX_STATUS) && (wb_adr_i[1:0] == 2'b00);
      mem_full = (st.count == CW'(DEPTH));
      // room means a whole cell fits, so a started cell never overflows
      have_room = (st.count <= CW'(DEPTH - WORDS_PER_CELL)); // [R8]
      out_take = st.out_valid && word_ready_i;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wr_word.soc = st.ctl[CTL_SOC]; // [R7] [R11]
      wr_word.data = {st.hold, wb_dat_i[7:0]}; // [R5]
      next_st.ack = req && mapped;
      next_st.err = req && !mapped;

      if (wr_req && mapped) begin
         case (idx)
            IDX_CONTROL: next_st.ctl = (wb_dat_i[7:0] & CTL_RW_MASK) | (st.ctl & ~CTL_RW_MASK); // [R6]
            IDX_BITS_31_24: next_st.hold[23:16] = wb_dat_i[7:0]; // [R2]
            IDX_BITS_23_16: next_st.hold[15:8] = wb_dat_i[7:0]; // [R3]
            IDX_BITS_15_8: next_st.hold[7:0] = wb_dat_i[7:0]; // [R4]
            IDX_BITS_7_0: begin
               // a word arriving with the buffer full is dropped and flagged
               if (!mem_full && st.ctl[CTL_INS_RST_N]) begin
                  wr_en = 1'b1; // [R11]
               end else begin
                  next_st.ovf = 1'b1;
               end
            end
            IDX_STATUS: begin
               if (wb_dat_i[0]) next_st.ovf = 1'b0;
            end
            default: ;
         endcase
      end

      if (req && !wb_we_i && mapped) begin
         case (idx)
            IDX_CONTROL: begin
               next_st.rdat = {24'h0000_00, st.ctl};
               next_st.rdat[CTL_ROOM] = have_room; // [R8]
               next_st.rdat[CTL_EXT_READY] = extract_cell_ready_i;
            end
            IDX_BITS_31_24: next_st.rdat = {24'h0000_00, ext_word_i[31:24]}; // [R10]
            IDX_BITS_23_16: next_st.rdat = {24'h0000_00, ext_word_i[23:16]}; // [R10]
            IDX_BITS_15_8: next_st.rdat = {24'h0000_00, ext_word_i[15:8]}; // [R10]
            IDX_BITS_7_0: next_st.rdat = {24'h0000_00, ext_word_i[7:0]}; // [R10]
            IDX_STATUS: next_st.rdat = {st.count == '0, st.ovf, 22'h00_0000, 8'(st.count)};
            default: next_st.rdat = '0;
         endcase
      end else if (!req) begin
         next_st.rdat = '0;
      end

      // memory read is registered: one cycle to fetch into the output stage
      if (st.mem_pending) begin
         next_st.out_valid = 1'b1;
         next_st.out_data = rd_word.data;
         next_st.out_soc = rd_word.soc;
         next_st.mem_pending = 1'b0;
      end else if (out_take) begin
         next_st.out_valid = 1'b0;
      end
      if (st.count != '0 && !st.mem_pending && (!st.out_valid || out_take)) begin
         rd_en = 1'b1;
         next_st.mem_pending = 1'b1;
         next_st.rptr = ptr_inc(st.rptr);
      end
      if (wr_en) next_st.wptr = ptr_inc(st.wptr);
      next_st.count = st.count + CW'(wr_en) - CW'(rd_en);

      // insertion reset bit low holds the buffer empty
      if (!st.ctl[CTL_INS_RST_N]) begin
         next_st.wptr = '0;
         next_st.rptr = '0;
         next_st.count = '0;
         next_st.mem_pending = 1'b0;
         next_st.out_valid = 1'b0;
         next_st.hold = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.ctl <= CTL_RESET;
      end else begin
         st <= next_st;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      wb_ack_o = st.ack;
      wb_err_o = st.err;
      wb_dat_o = st.rdat;
      word_valid_o = st.out_valid;
      word_data_o = st.out_data;
      word_soc_o = st.out_soc;
      ext_reset_o = !st.ctl[CTL_EXT_RST_N];
   end
endmodule
`default_nettype wire

// ===== testbench/rx_cell_insertion_write_port_checker.sv
`timescale 1ns/10ps
`default_nettype none
module rx_cell_insertion_write_port_checker
   import cell_ins_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic [31:0] ext_word_i,
   input wire logic extract_cell_ready_i,
   input wire logic word_ready_i,
   input wire logic word_valid_o,
   input wire logic [31:0] word_data_o,
   input wire logic word_soc_o
);
   logic tk, wr, en, soc, es;
   logic [31:0] sh, ew;
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wr = tk && wb_we_i && wb_sel_i[0] && wb_adr_i[1:0] == 2'b00;
   // shadow only valid for a lone word in flight; later commits overwrite it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en <= 1'b1;
         soc <= 1'b0;
      end else if (wr && wb_adr_i == 10'h04C) begin
         en <= wb_dat_i[CTL_INS_RST_N];
         soc <= wb_dat_i[CTL_SOC];
      end
      if (wr && wb_adr_i[9:4] == 6'h05) begin
         sh[8*(3 - int'(wb_adr_i[3:2])) +: 8] <= wb_dat_i[7:0];
      end
      if (wr && en && wb_adr_i == 10'h05C) begin
         ew <= {sh[31:8], wb_dat_i[7:0]};
         es <= soc;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rd; tk && !wb_we_i && wb_adr_i == 10'h050
      |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(ext_word_i[31:24])}; endproperty
   a_rd: assert property (p_rd) else $error("read data");
   property p_data; $rose(word_valid_o) |-> word_data_o == ew; endproperty
   a_data: assert property (p_data) else $error("word bytes");
   property p_soc; $rose(word_valid_o) |-> word_soc_o == es; endproperty
   a_soc: assert property (p_soc) else $error("soc tag");
   property p_cmt; wr && en && wb_adr_i == 10'h05C |-> ##[1:6] word_valid_o; endproperty
   a_cmt: assert property (p_cmt) else $error("no commit");
   property p_hold; word_valid_o && !word_ready_i && en ##1 en
      |-> word_valid_o && $stable(word_data_o); endproperty
   a_hold: assert property (p_hold) else $error("word not held");
   property p_ctl; tk && !wb_we_i && wb_adr_i == 10'h04C |=> wb_dat_o[0] == soc
      && wb_dat_o[2] == en && wb_dat_o[3] == $past(extract_cell_ready_i); endproperty
   a_ctl: assert property (p_ctl) else $error("control read");
   property p_err; tk && (wb_adr_i[1:0] != 2'b00 || wb_adr_i[9:2] < 8'h13
      || wb_adr_i[9:2] > 8'h18) |=> wb_err_o && !wb_ack_o; endproperty
   a_err: assert property (p_err) else $error("misaligned");
   property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack width");
endmodule
bind rx_cell_insertion_write_port rx_cell_insertion_write_port_checker chk_u (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .wb_err_o, .ext_word_i, .extract_cell_ready_i, .word_ready_i, .word_valid_o,
   .word_data_o, .word_soc_o);
`default_nettype wire

// ===== testbench/tb_rx_cell_insertion_write_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rx_cell_insertion_write_port;
   import cell_ins_pkg::*;
   logic clk_i = 0, rst_i = 1, xr = 1, rdy = 0, ack, err, wv, ws, xrst, e;
   wb_req_s rq = '0;
   logic [31:0] xw = 32'h1234_5678, dout, wd, r;
   int n_errors = 0, n_compared = 0, k;
   rx_cell_insertion_write_port #(.CELLS(1)) dut_u (.clk_i, .rst_i, .wb_cyc_i(rq.cyc),
      .wb_stb_i(rq.stb), .wb_we_i(rq.we), .wb_adr_i(rq.adr), .wb_sel_i(rq.sel),
      .wb_dat_i(rq.dat), .wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err), .ext_word_i(xw),
      .extract_cell_ready_i(xr), .word_ready_i(rdy), .word_valid_o(wv), .word_data_o(wd),
      .word_soc_o(ws), .ext_reset_o(xrst));
   initial forever #5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task acc(input logic w, input logic [7:0] i, input logic [7:0] d);
      k = 0;
      rq <= {1'b1, 1'b1, w, i, 2'b00, 4'h1, 24'h00_0000, d};
      do @(posedge clk_i); while (!(ack || err) && ++k < 40);
      if (k >= 40) n_errors++;
      r = dout;
      e = err;
      rq <= '0;
      @(posedge clk_i);
   endtask
   task word(input logic [31:0] w);
      for (int b = 0; b < 4; b++) acc(1, IDX_BITS_31_24 + 8'(b), w[31-8*b -: 8]);
   endtask
   task drain(input logic [31:0] w, input logic s);
      k = 0;
      while (wv !== 1'b1 && k++ < 20) @(posedge clk_i);
      chk(wd, w);
      chk(32'(ws), 32'(s));
      rdy <= 1;
      @(posedge clk_i);
      rdy <= 0;
   endtask
   task report_and_stop;
      if (n_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      acc(0, IDX_CONTROL, 0);
      chk(r, 32'h0000_001E);
      xr <= 0;
      for (int b = 0; b < 4; b++) begin
         acc(0, IDX_BITS_31_24 + 8'(b), 8'hFF);
         chk(r, 32'(xw[31-8*b -: 8]));
      end
      acc(0, 8'h20, 0);
      chk(32'(e), 1);
      for (int i = 0; i < WORDS_PER_CELL; i++) begin
         acc(1, IDX_CONTROL, i == 0 ? 8'h15 : 8'h14);
         word(32'hA0B0_C0D0 + 32'(i) * 32'h0101_0101);
         drain(32'hA0B0_C0D0 + 32'(i) * 32'h0101_0101, i == 0);
      end
      // no drain: a whole cell leaves one memory slot free, its first word held in the output stage
      acc(1, IDX_CONTROL, 8'h15);
      for (int i = 0; i < WORDS_PER_CELL; i++) begin
         word(32'h1111_1111 * 32'(i + 1));
         if (i == 0) acc(1, IDX_CONTROL, 8'h14);
      end
      acc(0, IDX_CONTROL, 0);
      chk(r, 32'h0000_0014);
      // the output stage already holds the first word: the first extra word fills the free memory slot, the second overflows
      acc(1, IDX_BITS_7_0, 8'hEE);
      acc(1, IDX_BITS_7_0, 8'hEE);
      acc(0, IDX_STATUS, 0);
      chk(32'(r[30]), 1);
      acc(1, IDX_CONTROL, 8'h00);
      chk(32'(xrst), 1);
      acc(1, IDX_CONTROL, 8'h14);
      chk(32'(wv), 0);
      acc(0, IDX_CONTROL, 0);
      chk(r, 32'h0000_0016);
      report_and_stop;
   end
endmodule
`default_nettype wire
